// ### hw/itb_defines.vh
// itb_defines.vh: offsets, control byte fields and reset values of the
// interval timer block.
// assumes inclusion by bare name from the design files.
`ifndef ITB_DEFINES_VH
`define ITB_DEFINES_VH
`define ITB_BASE_ADDR 16'h4000
`define ITB_REGION_MASK 16'hc000
`define ITB_OFS_CH0 5'h00
`define ITB_OFS_CH1 5'h04
`define ITB_OFS_CH2 5'h08
`define ITB_OFS_CTRL 5'h0c
`define ITB_OFS_STAT_A 5'h10
`define ITB_OFS_STAT_B 5'h14
`define ITB_SEL_HI 7
`define ITB_SEL_LO 6
`define ITB_RW_HI 5
`define ITB_RW_LO 4
`define ITB_MODE_HI 3
`define ITB_MODE_LO 1
`define ITB_BCD_BIT 0
`define ITB_SEL_READBACK 2'h3
`define ITB_RW_LATCH 2'h0
`define ITB_RW_LSB 2'h1
`define ITB_RW_MSB 2'h2
`define ITB_RW_BOTH 2'h3
`define ITB_MODE_SHOT 3'h0
`define ITB_MODE_SQUARE 3'h3
`define ITB_RB_NO_COUNT 5
`define ITB_RB_NO_STATUS 4
`define ITB_COUNT_RESET 16'h0000
`define ITB_RDATA_RESET 8'h00
`endif

// ### hw/itb_channel.v
// itb_channel.v: one 16-bit down-counting channel with its byte-wide
// data port, latch, status read-back and single-shot / square modes.
// assumes one-cycle strobes from the register front end and a one-cycle
// count enable pulse for the channel's clock.
`timescale 1ns/10ps
`include "itb_defines.vh"
module itb_channel (
    input wire clk_sys,
    input wire reset_n,
    input wire tick,
    input wire cfg_we,
    input wire [7:0] cfg_byte,
    input wire latch_cmd,
    input wire status_cmd,
    input wire data_we,
    input wire data_re,
    input wire [7:0] wdata,
    output wire [7:0] rdata,
    output reg out_reg
);
    reg [15:0] count_reg;
    reg [15:0] reload_reg;
    reg [15:0] latch_reg;
    reg latched_reg;
    reg [7:0] status_reg;
    reg status_valid_reg;
    reg [1:0] rw_reg;
    reg [2:0] mode_reg;
    reg bcd_reg;
    reg wr_hi_reg;
    reg rd_hi_reg;
    reg [7:0] low_hold_reg;
    reg load_pend_reg;
    reg running_reg;
    reg null_reg;
    wire [15:0] src;
    wire hi_sel;
    wire write_done;
    wire [15:0] new_val;

    // decrement by step (1 to 3) in binary or bcd
    function [15:0] itb_dec;
        input [15:0] v;
        input bcd;
        input [1:0] step;
        reg [15:0] r;
        integer i;
        begin
            r = v;
            if (!bcd) begin
                r = v - {14'h0000, step};
            end else begin
                for (i = 0; i < step; i = i + 1) begin
                    if (r[3:0] != 4'h0) r[3:0] = r[3:0] - 4'h1;
                    else begin
                        r[3:0] = 4'h9;
                        if (r[7:4] != 4'h0) r[7:4] = r[7:4] - 4'h1;
                        else begin
                            r[7:4] = 4'h9;
                            if (r[11:8] != 4'h0) r[11:8] = r[11:8] - 4'h1;
                            else begin
                                r[11:8] = 4'h9;
                                r[15:12] = (r[15:12] != 4'h0) ?
                                    r[15:12] - 4'h1 : 4'h9;
                            end
                        end
                    end
                end
            end
            itb_dec = r;
        end
    endfunction

    // which byte the next data write moves
    assign hi_sel = (rw_reg == `ITB_RW_MSB) ||
        (rw_reg == `ITB_RW_BOTH && wr_hi_reg);
    assign write_done = data_we &&
        (rw_reg != `ITB_RW_BOTH || wr_hi_reg);
    assign new_val = (rw_reg == `ITB_RW_LSB) ? {8'h00, wdata} :
        (rw_reg == `ITB_RW_MSB) ? {wdata, 8'h00} :
        {wdata, low_hold_reg};
    assign src = latched_reg ? latch_reg : count_reg;
    // read path: status first, then latched or live count
    assign rdata = status_valid_reg ? status_reg :
        (((rw_reg == `ITB_RW_MSB) ||
          (rw_reg == `ITB_RW_BOTH && rd_hi_reg)) ? src[15:8] : src[7:0]);

    // configuration, byte sequencing, latch and read-back
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            rw_reg <= `ITB_RW_BOTH;
            mode_reg <= `ITB_MODE_SHOT;
            bcd_reg <= 1'b0;
            wr_hi_reg <= 1'b0;
            rd_hi_reg <= 1'b0;
            low_hold_reg <= 8'h00;
            latched_reg <= 1'b0;
            latch_reg <= `ITB_COUNT_RESET;
            status_valid_reg <= 1'b0;
            status_reg <= 8'h00;
        end else begin
            if (cfg_we) begin
                rw_reg <= cfg_byte[`ITB_RW_HI:`ITB_RW_LO];
                mode_reg <= cfg_byte[`ITB_MODE_HI:`ITB_MODE_LO];
                bcd_reg <= cfg_byte[`ITB_BCD_BIT];
                wr_hi_reg <= 1'b0;
                rd_hi_reg <= 1'b0;
                latched_reg <= 1'b0;
                status_valid_reg <= 1'b0;
            end else begin
                if (data_we && rw_reg == `ITB_RW_BOTH) begin
                    wr_hi_reg <= ~wr_hi_reg;
                    if (!wr_hi_reg) low_hold_reg <= wdata;
                end
                if (status_cmd && !status_valid_reg) begin
                    status_valid_reg <= 1'b1;
                    status_reg <= {out_reg, null_reg, rw_reg, mode_reg,
                        bcd_reg};
                end else if (data_re && status_valid_reg) begin
                    status_valid_reg <= 1'b0;
                end else if (data_re) begin
                    if (rw_reg == `ITB_RW_BOTH) rd_hi_reg <= ~rd_hi_reg;
                    if (rw_reg != `ITB_RW_BOTH || rd_hi_reg)
                        latched_reg <= 1'b0;
                end
                if (latch_cmd && !latched_reg) begin
                    latched_reg <= 1'b1;
                    latch_reg <= count_reg;
                end
            end
        end
    end

    // counting engine and output
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            count_reg <= `ITB_COUNT_RESET;
            reload_reg <= `ITB_COUNT_RESET;
            load_pend_reg <= 1'b0;
            running_reg <= 1'b0;
            null_reg <= 1'b1;
            out_reg <= 1'b1;
        end else begin
            if (cfg_we) begin
                running_reg <= 1'b0;
                load_pend_reg <= 1'b0;
                null_reg <= 1'b1;
                out_reg <= (cfg_byte[`ITB_MODE_HI:`ITB_MODE_LO] ==
                    `ITB_MODE_SHOT) ? 1'b0 : 1'b1;
            end else if (write_done) begin
                reload_reg <= new_val;
                load_pend_reg <= 1'b1;
                null_reg <= 1'b1;
                if (mode_reg == `ITB_MODE_SHOT)
                    out_reg <= 1'b0;
            end else if (tick) begin
                if (load_pend_reg && (mode_reg == `ITB_MODE_SHOT ||
                        !running_reg)) begin
                    // new count loads on the first tick after the write, unless a mode other than single shot is running
                    count_reg <= reload_reg;
                    load_pend_reg <= 1'b0;
                    running_reg <= 1'b1;
                    null_reg <= 1'b0;
                    if (mode_reg == `ITB_MODE_SQUARE) out_reg <= 1'b1;
                end else if (running_reg) begin
                    if (mode_reg == `ITB_MODE_SQUARE) begin
                        // two steps per tick, odd counts hold high longer
                        if (count_reg == 16'h0002 ||
                                (count_reg == 16'h0000 && 1'b1)) begin
                            count_reg <= reload_reg;
                            out_reg <= ~out_reg;
                            load_pend_reg <= 1'b0;
                            null_reg <= 1'b0;
                        end else if (count_reg[0] && !out_reg) begin
                            count_reg <= itb_dec(count_reg, bcd_reg, 2'd3);
                        end else if (count_reg[0]) begin
                            count_reg <= itb_dec(count_reg, bcd_reg, 2'd1);
                        end else begin
                            count_reg <= itb_dec(count_reg, bcd_reg, 2'd2);
                        end
                    end else begin
                        count_reg <= itb_dec(count_reg, bcd_reg, 2'd1);
                        if (count_reg == 16'h0001)
                            out_reg <= 1'b1;
                    end
                end
            end
        end
    end
endmodule // itb_channel

// ### hw/itb_timer.v
// itb_timer.v: three-channel interval timer behind a byte-wide register
// window on the local i/o bus, plus its expiry status register.
// assumes a single-cycle synchronous bus strobe and one count enable.
`timescale 1ns/10ps
`include "itb_defines.vh"
module itb_timer (
    input wire clk_sys,
    input wire reset_n,
    input wire count_tick,
    input wire bus_sel,
    input wire bus_write,
    input wire [15:0] bus_addr,
    input wire [7:0] bus_wdata,
    output reg [7:0] bus_rdata_reg,
    output reg bus_ack_reg,
    output reg [2:0] timer_out_reg,
    output reg [1:0] expiry_irq_reg
);
    wire hit;
    wire [4:0] ofs;
    wire wr;
    wire rd;
    wire ctrl_wr;
    wire rb_cmd;
    wire [1:0] ch_sel;
    wire [2:0] out_w;
    wire [23:0] rd_w;
    wire [2:0] cfg_we;
    wire [2:0] latch_cmd;
    wire [2:0] status_cmd;
    wire [2:0] data_we;
    wire [2:0] data_re;
    reg [2:0] out_prev_reg;
    reg [1:0] stat_reg;
    reg [1:0] stat_next;
    reg [7:0] rdata_next;
    genvar g;

    // address decode inside the timer region, low byte of each longword
    assign hit = bus_sel &&
        ((bus_addr & `ITB_REGION_MASK) == `ITB_BASE_ADDR) &&
        (bus_addr[13:5] == 9'h000) && (bus_addr[1:0] == 2'b00);
    assign ofs = bus_addr[4:0];
    assign wr = hit && bus_write;
    assign rd = hit && !bus_write;
    assign ctrl_wr = wr && ofs == `ITB_OFS_CTRL;
    assign ch_sel = bus_wdata[`ITB_SEL_HI:`ITB_SEL_LO];
    assign rb_cmd = ctrl_wr && ch_sel == `ITB_SEL_READBACK;

    // per-channel strobes and instances
    generate
        for (g = 0; g < 3; g = g + 1) begin : gen_ch
            assign cfg_we[g] = ctrl_wr && !rb_cmd && ch_sel == g &&
                bus_wdata[`ITB_RW_HI:`ITB_RW_LO] != `ITB_RW_LATCH;
            assign latch_cmd[g] = ctrl_wr && ((!rb_cmd && ch_sel == g &&
                bus_wdata[`ITB_RW_HI:`ITB_RW_LO] == `ITB_RW_LATCH) ||
                (rb_cmd && bus_wdata[g + 1] &&
                 !bus_wdata[`ITB_RB_NO_COUNT]));
            assign status_cmd[g] = rb_cmd && bus_wdata[g + 1] &&
                !bus_wdata[`ITB_RB_NO_STATUS];
            assign data_we[g] = wr && ofs == (g * 4);
            assign data_re[g] = rd && ofs == (g * 4);
            itb_channel u_ch (
                .clk_sys(clk_sys),
                .reset_n(reset_n),
                .tick(count_tick),
                .cfg_we(cfg_we[g]),
                .cfg_byte(bus_wdata),
                .latch_cmd(latch_cmd[g]),
                .status_cmd(status_cmd[g]),
                .data_we(data_we[g]),
                .data_re(data_re[g]),
                .wdata(bus_wdata),
                .rdata(rd_w[g * 8 +: 8]),
                .out_reg(out_w[g])
            );
        end
    endgenerate

    // expiry bits: rising output of channels 0 and 2; set beats clear
    always @* begin
        stat_next = stat_reg;
        if (rd && (ofs == `ITB_OFS_STAT_A || ofs == `ITB_OFS_STAT_B))
            stat_next = 2'b00;
        if (wr && ofs == `ITB_OFS_STAT_B)
            stat_next = stat_reg & ~bus_wdata[1:0];
        if (out_w[0] && !out_prev_reg[0]) stat_next[0] = 1'b1;
        if (out_w[2] && !out_prev_reg[2]) stat_next[1] = 1'b1;
    end

    // read data mux
    always @* begin
        rdata_next = `ITB_RDATA_RESET;
        case (ofs)
            `ITB_OFS_CH0: rdata_next = rd_w[7:0];
            `ITB_OFS_CH1: rdata_next = rd_w[15:8];
            `ITB_OFS_CH2: rdata_next = rd_w[23:16];
            `ITB_OFS_STAT_A: rdata_next = {6'h00, stat_reg};
            `ITB_OFS_STAT_B: rdata_next = {6'h00, stat_reg};
            default: rdata_next = `ITB_RDATA_RESET;
        endcase
    end

    // registered bus answer and outputs
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            bus_rdata_reg <= `ITB_RDATA_RESET;
            bus_ack_reg <= 1'b0;
            timer_out_reg <= 3'h7;
            out_prev_reg <= 3'h7;
            stat_reg <= 2'b00;
            expiry_irq_reg <= 2'b00;
        end else begin
            bus_ack_reg <= hit;
            bus_rdata_reg <= rd ? rdata_next : `ITB_RDATA_RESET;
            timer_out_reg <= out_w;
            out_prev_reg <= out_w;
            stat_reg <= stat_next;
            expiry_irq_reg <= stat_next;
        end
    end
endmodule // itb_timer

// ### tb/itb_timer_assertions.sv
// itb_timer_assertions.sv: port-level checks of the interval timer.
// assumes binding to itb_timer, one clock and synchronous reset_n.
`timescale 1ns/10ps
module itb_timer_assertions (
    input wire clk_sys,
    input wire reset_n,
    input wire count_tick,
    input wire bus_sel,
    input wire bus_write,
    input wire [15:0] bus_addr,
    input wire [7:0] bus_wdata,
    input wire [7:0] bus_rdata_reg,
    input wire bus_ack_reg,
    input wire [2:0] timer_out_reg,
    input wire [1:0] expiry_irq_reg
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // access that falls on a longword inside the timer window
    wire acc_hit = bus_sel && bus_addr[15:14] == 2'h1 &&
        bus_addr[13:5] == 9'h000 && bus_addr[1:0] == 2'h0;
    wire shot_cfg0 = acc_hit && bus_write && bus_addr[4:0] == 5'h0c &&
        bus_wdata[7:6] == 2'h0 && bus_wdata[5:4] != 2'h0 &&
        bus_wdata[3:1] == 3'h0;
    wire stat_read = acc_hit && !bus_write && bus_addr[4:0] == 5'h10;
    // no access and no tick for three cycles
    sequence quiet_s;
        (!count_tick && !bus_sel) [*3];
    endsequence
    sequence ch0_rise_s;
        $rose(timer_out_reg[0]);
    endsequence
    a_ack_decoded: assert property (acc_hit |=> bus_ack_reg)
        else $error("decoded access not acknowledged");
    a_no_stray_ack: assert property (!acc_hit |=> !bus_ack_reg)
        else $error("acknowledge without decoded access");
    a_rdata_idle: assert property (!bus_ack_reg |-> bus_rdata_reg == 8'h00)
        else $error("read data not zero outside acknowledge");
    a_reset_state: assert property ($rose(reset_n) |->
        timer_out_reg == 3'h7 && expiry_irq_reg == 2'h0)
        else $error("outputs wrong after reset");
    a_shot_cfg_low: assert property (shot_cfg0 |-> ##[1:2]
        !timer_out_reg[0]) else $error("single shot config left out high");
    a_ch0_expiry: assert property (ch0_rise_s |-> ##[1:2]
        expiry_irq_reg[0]) else $error("channel 0 rise not recorded");
    a_ch2_expiry: assert property ($rose(timer_out_reg[2]) |-> ##[1:2]
        expiry_irq_reg[1]) else $error("channel 2 rise not recorded");
    a_status_clear: assert property (stat_read && !count_tick |->
        ##[1:3] expiry_irq_reg == 2'h0) else $error("status read kept bits");
    a_out_needs_cause: assert property (quiet_s |=> $stable(timer_out_reg))
        else $error("output moved without tick or access");
endmodule // itb_timer_assertions

bind itb_timer itb_timer_assertions u_chk (.clk_sys(clk_sys),
    .reset_n(reset_n), .count_tick(count_tick), .bus_sel(bus_sel),
    .bus_write(bus_write), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_rdata_reg(bus_rdata_reg), .bus_ack_reg(bus_ack_reg),
    .timer_out_reg(timer_out_reg), .expiry_irq_reg(expiry_irq_reg));

// ### tb/itb_host_model.sv
// itb_host_model.sv: host processor on the byte-wide local i/o bus.
// assumes one-cycle strobes and an acknowledge one cycle after taking.
`timescale 1ns/10ps
module itb_host_model (
    input wire clk_sys,
    input wire [7:0] bus_rdata_reg,
    input wire bus_ack_reg,
    output reg bus_sel,
    output reg bus_write,
    output reg [15:0] bus_addr,
    output reg [7:0] bus_wdata
);
    initial begin
        bus_sel = 1'b0;
        bus_write = 1'b0;
        bus_addr = 16'h0000;
        bus_wdata = 8'h00;
    end
    // one byte access; address held until the answer edge
    task access(input wr, input [15:0] a, input [7:0] wd,
        output [7:0] rd, output ack);
        @(posedge clk_sys);
        bus_sel <= 1'b1;
        bus_write <= wr;
        bus_addr <= a;
        bus_wdata <= wd;
        @(posedge clk_sys);
        bus_sel <= 1'b0;
        @(posedge clk_sys);
        ack = bus_ack_reg;
        rd = bus_rdata_reg;
        // released lines show the inverse of the last value
        bus_addr <= ~bus_addr;
        bus_wdata <= ~bus_wdata;
    endtask
    // count write, low byte first when both bytes are used
    task put_count(input [15:0] a, input [1:0] rw, input [15:0] v);
        reg [7:0] r;
        reg k;
        if (rw[0]) access(1'b1, a, v[7:0], r, k);
        if (rw[1]) access(1'b1, a, v[15:8], r, k);
    endtask
endmodule // itb_host_model

// ### tb/itb_timer_tb_top.sv
// itb_timer_tb_top.sv: self-checking bench of the interval timer.
// assumes the host model drives the bus and the bench drives ticks.
`timescale 1ns/10ps
module itb_timer_tb_top;
    localparam [15:0] BASE = 16'h4000;
    reg clk_sys = 1'b0;
    reg reset_n = 1'b0;
    reg count_tick = 1'b0;
    wire bus_sel, bus_write, bus_ack_reg;
    wire [15:0] bus_addr;
    wire [7:0] bus_wdata, bus_rdata_reg;
    wire [2:0] timer_out_reg;
    wire [1:0] expiry_irq_reg;
    integer n_fail = 0;
    integer compares = 0;
    integer cycles = 0;
    reg [7:0] rd;
    reg ack;
    always #25 clk_sys = ~clk_sys;
    itb_timer dut (.clk_sys(clk_sys), .reset_n(reset_n),
        .count_tick(count_tick), .bus_sel(bus_sel), .bus_write(bus_write),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_rdata_reg(bus_rdata_reg), .bus_ack_reg(bus_ack_reg),
        .timer_out_reg(timer_out_reg), .expiry_irq_reg(expiry_irq_reg));
    itb_host_model host (.clk_sys(clk_sys), .bus_rdata_reg(bus_rdata_reg),
        .bus_ack_reg(bus_ack_reg), .bus_sel(bus_sel),
        .bus_write(bus_write), .bus_addr(bus_addr), .bus_wdata(bus_wdata));
    task chk(input string what, input [31:0] exp, input [31:0] got);
        compares = compares + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task wr(input [15:0] a, input [7:0] d);
        host.access(1'b1, a, d, rd, ack);
        chk("write ack", 32'h1, {31'h0, ack});
    endtask
    task rdc(input [15:0] a, input [7:0] exp, input [7:0] m, input string w);
        host.access(1'b0, a, 8'h00, rd, ack);
        chk(w, {24'h0, exp}, {24'h0, rd & m});
    endtask
    // one tick pulse, then two settle cycles
    task ticks(input integer k);
        repeat (k) begin
            @(posedge clk_sys) count_tick <= 1'b1;
            @(posedge clk_sys) count_tick <= 1'b0;
            repeat (2) @(posedge clk_sys);
        end
    endtask
    task ticks_until(input integer ch, input lvl, output integer n);
        n = 0;
        while (timer_out_reg[ch] !== lvl && n < 400) begin
            ticks(1);
            n = n + 1;
        end
    endtask
    task t_map;
        host.access(1'b0, BASE | 16'h0018, 8'h00, rd, ack);
        chk("unmapped ack", 32'h1, {31'h0, ack});
        chk("unmapped data", 32'h0, {24'h0, rd});
        host.access(1'b0, 16'h8000, 8'h00, rd, ack);
        chk("outside ack", 32'h0, {31'h0, ack});
    endtask
    // single shot on channel 0 in each write access order
    task t_shot;
        reg [7:0] ctl [0:2];
        reg [15:0] val [0:2];
        integer i, n;
        ctl[0] = 8'h30;
        val[0] = 16'h0003;
        ctl[1] = 8'h10;
        val[1] = 16'h0002;
        ctl[2] = 8'h20;
        val[2] = 16'h0100;
        for (i = 0; i < 3; i = i + 1) begin
            wr(BASE | 16'h000c, ctl[i]);
            host.put_count(BASE, ctl[i][5:4], val[i]);
            chk("shot low", 32'h0, {31'h0, timer_out_reg[0]});
            ticks_until(0, 1'b1, n);
            chk("shot ticks", val[i] + 1, n);
        end
    endtask
    task t_square;
        integer n;
        wr(BASE | 16'h000c, 8'hb6);
        host.put_count(BASE | 16'h0008, 2'h3, 16'h0005);
        ticks_until(2, 1'b0, n);
        ticks_until(2, 1'b1, n);
        ticks_until(2, 1'b0, n);
        chk("square high", 32'h3, n);
        ticks_until(2, 1'b1, n);
        chk("square low", 32'h2, n);
        wr(BASE | 16'h000c, 8'hb0); // park channel 2 in single shot
    endtask
    task t_status;
        chk("irq before", 32'h3, {30'h0, expiry_irq_reg});
        // write-1-clear at the second alias drops only the bits written
        wr(BASE | 16'h0014, 8'h01);
        chk("irq w1c", 32'h2, {30'h0, expiry_irq_reg});
        rdc(BASE | 16'h0010, 8'h02, 8'h03, "status first");
        @(posedge clk_sys);
        chk("irq cleared", 32'h0, {30'h0, expiry_irq_reg});
        rdc(BASE | 16'h0014, 8'h00, 8'h03, "status alias");
    endtask
    // bcd count on channel 1, latch, then read-back of status and count
    task t_readback;
        wr(BASE | 16'h000c, 8'h71);
        host.put_count(BASE | 16'h0004, 2'h3, 16'h1000);
        chk("ch1 low", 32'h0, {31'h0, timer_out_reg[1]});
        ticks(2);
        wr(BASE | 16'h000c, 8'h40);
        ticks(1);
        rdc(BASE | 16'h0004, 8'h99, 8'hff, "latch low");
        rdc(BASE | 16'h0004, 8'h09, 8'hff, "latch high");
        wr(BASE | 16'h000c, 8'hc4);
        ticks(1); // live count moves on, the frozen copy must not
        rdc(BASE | 16'h0004, 8'h31, 8'hbf, "status byte");
        rdc(BASE | 16'h0004, 8'h98, 8'hff, "frozen low");
        rdc(BASE | 16'h0004, 8'h09, 8'hff, "frozen high");
    endtask
    task tally_and_finish;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // every channel is configured before it is relied on
    initial begin
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_map;
        t_shot;
        t_square;
        t_status;
        t_readback;
        tally_and_finish;
    end
    // hang guard
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail = n_fail + 1;
            tally_and_finish;
        end
    end
endmodule // itb_timer_tb_top
